/* File: rtl/upcd_defines.svh */
// constants for the usb port change detect block
// Summary of operation
// - detection runs in sleep and active
// - device mode: supply input change sets flag
// - supply change reaches device summary when enabled
// - live supply present bit readable
// - host mode: fault input sets fault flag
// - fault flag reaches host summary when enabled
// - power switch pin follows power enable bit
// - host supply state bit mirrors fault input
// - line state change sets line flag
// - line flag reaches host summary when enabled
// - two-bit live line state readable
// - leaving se0 on attach raises line flag
// - transceiver control holds two-bit mode field
// - settings kept; in host role a step code lets hardware update the power bit
// - line flag separate, works while host unused
// - role bit 1 host, 0 device, sleep only
`ifndef UPCD_DEFINES_SVH
`define UPCD_DEFINES_SVH
// ***********************************************
// register offsets
// ***********************************************
`define UPCD_A_DEV_STAT 4'h0
`define UPCD_A_DEV_EN 4'h1
`define UPCD_A_HOST_STAT 4'h2
`define UPCD_A_HOST_EN 4'h3
`define UPCD_A_TOP_SUM 4'h4
`define UPCD_A_TOP_MASK 4'h5
`define UPCD_A_XCVR 4'h6
`define UPCD_A_HOST_CTRL 4'h7
`define UPCD_A_STATUS 4'h8
`define UPCD_A_STEP 4'h9
`define UPCD_A_ROLE 4'hA
// ***********************************************
// field positions
// ***********************************************
`define UPCD_B_SUPPLY_CHG 0
`define UPCD_B_FAULT 0
`define UPCD_B_LINES 1
`define UPCD_B_DEV_SUM 0
`define UPCD_B_HOST_SUM 1
`define UPCD_B_PWR 0
`define UPCD_B_ST_VBUS 0
`define UPCD_B_ST_OK 1
`define UPCD_B_ST_LINE 2
// ***********************************************
// reset values
// ***********************************************
`define UPCD_R_XCVR 8'h00
`define UPCD_R_STEP 4'h0
// step codes that hardware acts on
`define UPCD_STEP_IDLE 4'h0
`define UPCD_STEP_POWER_OFF 4'h1
`define UPCD_STEP_POWER_ON 4'h2
`endif

/* File: rtl/upcd_pkg.sv */
// types for the usb port change detect block
package upcd_pkg;
  // role of the port
  typedef enum logic [0:0] {
    UPCD_ROLE_DEVICE = 1'b0,
    UPCD_ROLE_HOST = 1'b1
  } upcd_role_t;
endpackage

/* File: rtl/upcd_port_change.sv */
// usb port change detection with its own register file
`timescale 1ns/1ps
`include "upcd_defines.svh"
module upcd_port_change
  import upcd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic vbus_in,
  input wire logic supply_fault_in,
  input wire logic [1:0] cable_line_level,
  output logic power_switch_out,
  // summary toward the top interrupt
  output logic top_irq
);
  // ***********************************************
  // registers
  // ***********************************************
  logic supply_change_flag; // sticky
  logic supply_fault_flag; // sticky
  logic bus_lines_moved_flag; // sticky
  logic supply_change_irq_en;
  logic supply_fault_irq_en;
  logic bus_lines_moved_irq_en;
  logic [1:0] top_irq_mask; // dev and host summary enables
  logic [7:0] transceiver_ctrl; // mode in low two bits
  logic power_switch_on;
  logic [3:0] host_state_step_code;
  upcd_role_t role_select;
  logic vbus_q; // last sampled supply level
  logic [1:0] line_q; // last sampled line level
  logic [7:0] rdata_q;

  // ***********************************************
  // decode
  // ***********************************************
  wire wr_dev_stat = reg_wr && reg_addr == `UPCD_A_DEV_STAT;
  wire wr_dev_en = reg_wr && reg_addr == `UPCD_A_DEV_EN;
  wire wr_host_stat = reg_wr && reg_addr == `UPCD_A_HOST_STAT;
  wire wr_host_en = reg_wr && reg_addr == `UPCD_A_HOST_EN;
  wire wr_mask = reg_wr && reg_addr == `UPCD_A_TOP_MASK;
  wire wr_xcvr = reg_wr && reg_addr == `UPCD_A_XCVR;
  wire wr_hctrl = reg_wr && reg_addr == `UPCD_A_HOST_CTRL;
  wire wr_step = reg_wr && reg_addr == `UPCD_A_STEP;
  wire wr_role = reg_wr && reg_addr == `UPCD_A_ROLE;
  wire [1:0] phy_operating_sel = transceiver_ctrl[1:0];
  wire is_host = role_select == UPCD_ROLE_HOST;

  // ***********************************************
  // events
  // ***********************************************
  // detection never looks at any power state, so sleep works too
  wire ev_supply = !is_host && (vbus_in != vbus_q);
  // fault input is active low: low means the switch reports trouble
  wire ev_fault = is_host && !supply_fault_in;
  // any move, including leaving se0 on attach, in either role
  wire ev_lines = cable_line_level != line_q;
  wire host_supply_ok = supply_fault_in;

  // ***********************************************
  // summary
  // ***********************************************
  wire dev_sum = supply_change_flag && supply_change_irq_en;
  wire host_sum = (supply_fault_flag && supply_fault_irq_en)
    || (bus_lines_moved_flag && bus_lines_moved_irq_en);
  wire [7:0] top_irq_summary = {6'h00, host_sum, dev_sum};
  wire [7:0] status_word = {4'h0, cable_line_level,
    host_supply_ok, vbus_in};

  // read mux; unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      `UPCD_A_DEV_STAT: next_rdata = {7'h00, supply_change_flag};
      `UPCD_A_DEV_EN: next_rdata = {7'h00, supply_change_irq_en};
      `UPCD_A_HOST_STAT: next_rdata = {6'h00, bus_lines_moved_flag,
        supply_fault_flag};
      `UPCD_A_HOST_EN: next_rdata = {6'h00, bus_lines_moved_irq_en,
        supply_fault_irq_en};
      `UPCD_A_TOP_SUM: next_rdata = top_irq_summary;
      `UPCD_A_TOP_MASK: next_rdata = {6'h00, top_irq_mask};
      `UPCD_A_XCVR: next_rdata = transceiver_ctrl;
      `UPCD_A_HOST_CTRL: next_rdata = {7'h00, power_switch_on};
      `UPCD_A_STATUS: next_rdata = status_word;
      `UPCD_A_STEP: next_rdata = {4'h0, host_state_step_code};
      `UPCD_A_ROLE: next_rdata = {7'h00, role_select};
      default: next_rdata = 8'h00;
    endcase
  end

  // ***********************************************
  // sticky flags: write 1 clears, event wins over clear
  // ***********************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      supply_change_flag <= 1'b0;
      supply_fault_flag <= 1'b0;
      bus_lines_moved_flag <= 1'b0;
    end else begin
      supply_change_flag <= ev_supply || (supply_change_flag &&
        !(wr_dev_stat && reg_wdata[`UPCD_B_SUPPLY_CHG]));
      supply_fault_flag <= ev_fault || (supply_fault_flag &&
        !(wr_host_stat && reg_wdata[`UPCD_B_FAULT]));
      bus_lines_moved_flag <= ev_lines || (bus_lines_moved_flag &&
        !(wr_host_stat && reg_wdata[`UPCD_B_LINES]));
    end
  end

  // ***********************************************
  // input history for change detection
  // ***********************************************
  // inputs are sampled only after release; the first compare after release is against the reset value 0
  logic primed;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      primed <= 1'b0;
      vbus_q <= 1'b0;
      line_q <= 2'b00;
    end else begin
      primed <= 1'b1;
      vbus_q <= vbus_in;
      line_q <= cable_line_level;
    end
  end

  // ***********************************************
  // enables, mask, role
  // ***********************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      supply_change_irq_en <= 1'b0;
      supply_fault_irq_en <= 1'b0;
      bus_lines_moved_irq_en <= 1'b0;
      top_irq_mask <= 2'b00;
      role_select <= UPCD_ROLE_DEVICE;
    end else begin
      if (wr_dev_en)
        supply_change_irq_en <= reg_wdata[`UPCD_B_SUPPLY_CHG];
      if (wr_host_en) begin
        supply_fault_irq_en <= reg_wdata[`UPCD_B_FAULT];
        bus_lines_moved_irq_en <= reg_wdata[`UPCD_B_LINES];
      end
      if (wr_mask)
        top_irq_mask <= reg_wdata[1:0];
      // software switches role only in sleep; not checked here
      if (wr_role)
        role_select <= upcd_role_t'(reg_wdata[0]);
    end
  end

  // ***********************************************
  // transceiver and power control with host step codes
  // ***********************************************
  // values survive a role change; only writes or step codes move them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      transceiver_ctrl <= `UPCD_R_XCVR;
      power_switch_on <= 1'b0;
      host_state_step_code <= `UPCD_R_STEP;
    end else begin
      if (wr_xcvr)
        transceiver_ctrl <= reg_wdata;
      if (wr_hctrl)
        power_switch_on <= reg_wdata[`UPCD_B_PWR];
      if (wr_step)
        host_state_step_code <= reg_wdata[3:0];
      else if (is_host && host_state_step_code != `UPCD_STEP_IDLE) begin
        host_state_step_code <= `UPCD_STEP_IDLE;
        power_switch_on <= host_state_step_code == `UPCD_STEP_POWER_ON;
      end
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
      power_switch_out <= 1'b0;
      top_irq <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? next_rdata : 8'h00;
      power_switch_out <= power_switch_on;
      top_irq <= |(top_irq_summary & {6'h00, top_irq_mask});
    end
  end
  assign reg_rdata = rdata_q;

  // ***********************************************
  // checks
  // ***********************************************
  // a change of the supply level in device role is never lost
  AST_SUPPLY_SET: assert property (
    @(posedge clk) disable iff (!rst_b)
    ev_supply |=> supply_change_flag)
    else $error("supply change not flagged");
  // device summary bit is the flag gated by its enable
  AST_DEV_SUM: assert property (
    @(posedge clk) disable iff (!rst_b)
    top_irq_summary[0] == (supply_change_flag && supply_change_irq_en))
    else $error("device summary wrong");
  // a low fault input in host role always lands in the flag
  AST_FAULT_SET: assert property (
    @(posedge clk) disable iff (!rst_b)
    (is_host && !supply_fault_in) |=> supply_fault_flag)
    else $error("fault not flagged");
  // pin trails the control bit by exactly one edge
  AST_PWR_PIN: assert property (
    @(posedge clk) disable iff (!rst_b)
    primed |-> power_switch_out == $past(power_switch_on))
    else $error("power pin does not follow bit");
  // any move of the line pair sets the line flag
  AST_LINE_SET: assert property (
    @(posedge clk) disable iff (!rst_b)
    (primed && cable_line_level != $past(cable_line_level))
    |=> bus_lines_moved_flag)
    else $error("line change not flagged");
  // a masked line flag alone never reaches the host summary
  AST_HOST_SUM: assert property (
    @(posedge clk) disable iff (!rst_b)
    (bus_lines_moved_flag && !bus_lines_moved_irq_en && !supply_fault_flag)
    |-> !top_irq_summary[1])
    else $error("masked line flag reached summary");
  // supply flag only drops on a write to its status
  AST_STICKY: assert property (
    @(posedge clk) disable iff (!rst_b)
    (supply_change_flag && !wr_dev_stat) |=> supply_change_flag)
    else $error("flag dropped without clear");
  // live supply bit as read back
  AST_STATUS_RD: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `UPCD_A_STATUS)
    |=> reg_rdata[0] == $past(vbus_in))
    else $error("supply present bit wrong");
  // supply moves are ignored while the port acts as host
  AST_SUPPLY_HOST: assert property (
    @(posedge clk) disable iff (!rst_b)
    (is_host && !supply_change_flag) |=> !supply_change_flag)
    else $error("supply flag set in host role");
  // fault input is ignored while the port acts as device
  AST_FAULT_DEV: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!is_host && !supply_fault_flag) |=> !supply_fault_flag)
    else $error("fault flag set in device role");
  // an enabled fault flag drives the host summary
  AST_FAULT_SUM: assert property (
    @(posedge clk) disable iff (!rst_b)
    (supply_fault_flag && supply_fault_irq_en) |-> top_irq_summary[1])
    else $error("enabled fault missing from summary");
  // with both host sources quiet the summary stays low
  AST_FAULT_MASKED: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!supply_fault_irq_en
      && !(bus_lines_moved_flag && bus_lines_moved_irq_en))
    |-> !top_irq_summary[1])
    else $error("masked fault reached summary");
  // an enabled line flag drives the host summary
  AST_LINE_SUM: assert property (
    @(posedge clk) disable iff (!rst_b)
    (bus_lines_moved_flag && bus_lines_moved_irq_en)
    |-> top_irq_summary[1])
    else $error("enabled line flag missing from summary");
  // top output is the masked summary one edge later
  AST_TOP_IRQ: assert property (
    @(posedge clk) disable iff (!rst_b)
    primed |-> top_irq == $past(|(top_irq_summary[1:0] & top_irq_mask)))
    else $error("top interrupt output wrong");
  // host supply state bit as read back
  AST_OK_RD: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `UPCD_A_STATUS)
    |=> reg_rdata[1] == $past(supply_fault_in))
    else $error("host supply state bit wrong");
  // live line pair as read back
  AST_LINE_RD: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `UPCD_A_STATUS)
    |=> reg_rdata[3:2] == $past(cable_line_level))
    else $error("line state field wrong");
  // read data stand one cycle only, zero otherwise
  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  // whole transceiver byte reads back, mode field included
  AST_XCVR_RD: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `UPCD_A_XCVR)
    |=> reg_rdata == $past(transceiver_ctrl))
    else $error("transceiver control readback wrong");
  // in host role a pending step code is consumed at the next edge
  AST_STEP_CLEAR: assert property (
    @(posedge clk) disable iff (!rst_b)
    (is_host && host_state_step_code != `UPCD_STEP_IDLE && !wr_step)
    |=> host_state_step_code == `UPCD_STEP_IDLE)
    else $error("step code not consumed");
  // the power-on step code turns the switch on
  AST_STEP_PWR: assert property (
    @(posedge clk) disable iff (!rst_b)
    (is_host && host_state_step_code == `UPCD_STEP_POWER_ON && !wr_step)
    |=> power_switch_on)
    else $error("power-on step ignored");
  // transceiver settings move only on a write
  AST_KEEP_XCVR: assert property (
    @(posedge clk) disable iff (!rst_b)
    !wr_xcvr |=> transceiver_ctrl == $past(transceiver_ctrl))
    else $error("transceiver control changed by itself");
  // power bit moves only on a write or a consumed step code
  AST_KEEP_PWR: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!wr_hctrl && !(is_host && host_state_step_code != `UPCD_STEP_IDLE))
    |=> power_switch_on == $past(power_switch_on))
    else $error("power bit changed by itself");
  // fault flag only drops on a write to host status
  AST_FAULT_STICKY: assert property (
    @(posedge clk) disable iff (!rst_b)
    (supply_fault_flag && !wr_host_stat) |=> supply_fault_flag)
    else $error("fault flag dropped without clear");
  // line flag only drops on a write to host status
  AST_LINE_STICKY: assert property (
    @(posedge clk) disable iff (!rst_b)
    (bus_lines_moved_flag && !wr_host_stat) |=> bus_lines_moved_flag)
    else $error("line flag dropped without clear");
  // a clear with no new event empties the supply flag
  AST_SUPPLY_CLEAR: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_dev_stat && reg_wdata[`UPCD_B_SUPPLY_CHG] && !ev_supply)
    |=> !supply_change_flag)
    else $error("supply flag survived clear");
  // a clear with no new event empties the line flag
  AST_LINE_CLEAR: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_host_stat && reg_wdata[`UPCD_B_LINES] && !ev_lines)
    |=> !bus_lines_moved_flag)
    else $error("line flag survived clear");
  // role bit takes the written value
  AST_ROLE_WR: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_role |=> role_select == $past(reg_wdata[0]))
    else $error("role bit not written");
  // line watching keeps going while the host side is unused
  AST_LINE_DEV: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!is_host && ev_lines) |=> bus_lines_moved_flag)
    else $error("line change lost in device role");
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the port change detect block
`timescale 1ns/1ps
`include "upcd_defines.svh"
module tb_top;
  // ***********************************************
  // signals
  // ***********************************************
  logic clk, rst_b, reg_wr, reg_rd, power_switch_out, top_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic vbus_in, supply_fault_in, supply_on, fault_cmd, attach;
  logic [1:0] cable_line_level;
  int mismatches, checks;
  upcd_port_change dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vbus_in(vbus_in),
    .supply_fault_in(supply_fault_in), .cable_line_level(cable_line_level),
    .power_switch_out(power_switch_out), .top_irq(top_irq));
  upcd_peer_model peer (.clk(clk), .supply_on(supply_on),
    .fault_cmd(fault_cmd), .attach(attach),
    .power_switch_out(power_switch_out), .vbus_in(vbus_in),
    .supply_fault_in(supply_fault_in), .cable_line_level(cable_line_level));
  // ***********************************************
  // tasks
  // ***********************************************
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ***********************************************
  // clock, watchdog and tests
  // ***********************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // tests need about 150 cycles; allow far more
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, supply_on, fault_cmd, attach} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    mismatches = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // device role: idle pins, unmapped index
    rd(`UPCD_A_STATUS, 8'h02);
    rd(`UPCD_A_DEV_STAT, 8'h00);
    rd(4'hF, 8'h00);
    // line watching also runs in device role
    attach <= 1'b1;
    wait_clk(4);
    rd(`UPCD_A_HOST_STAT, 8'h02);
    attach <= 1'b0;
    wait_clk(4);
    wr(`UPCD_A_HOST_STAT, 8'h02);
    rd(`UPCD_A_HOST_STAT, 8'h00);
    supply_on <= 1'b1;
    wait_clk(4);
    rd(`UPCD_A_DEV_STAT, 8'h01);
    rd(`UPCD_A_STATUS, 8'h03);
    wait_clk(1);
    chk("rdata idle", 8'h00, reg_rdata);
    rd(`UPCD_A_TOP_SUM, 8'h00);
    wr(`UPCD_A_DEV_EN, 8'h01);
    wr(`UPCD_A_TOP_MASK, 8'h03);
    rd(`UPCD_A_TOP_SUM, 8'h01);
    wait_clk(3);
    chk("top_irq", 8'h01, {7'h00, top_irq});
    wr(`UPCD_A_DEV_STAT, 8'h01);
    rd(`UPCD_A_DEV_STAT, 8'h00);
    rd(`UPCD_A_TOP_SUM, 8'h00);
    wait_clk(3);
    chk("top_irq", 8'h00, {7'h00, top_irq});
    // host role: transceiver, power switch and step codes
    wr(`UPCD_A_ROLE, 8'h01);
    wr(`UPCD_A_XCVR, 8'h93);
    rd(`UPCD_A_XCVR, 8'h93);
    wr(`UPCD_A_HOST_CTRL, 8'h01);
    wait_clk(3);
    chk("power", 8'h01, {7'h00, power_switch_out});
    wr(`UPCD_A_STEP, `UPCD_STEP_POWER_OFF);
    wait_clk(3);
    chk("power", 8'h00, {7'h00, power_switch_out});
    rd(`UPCD_A_XCVR, 8'h93);
    wr(`UPCD_A_STEP, `UPCD_STEP_POWER_ON);
    wait_clk(3);
    chk("power", 8'h01, {7'h00, power_switch_out});
    rd(`UPCD_A_STEP, 8'h00);
    wr(`UPCD_A_STEP, 8'h05);
    wait_clk(3);
    chk("power", 8'h00, {7'h00, power_switch_out});
    wr(`UPCD_A_HOST_CTRL, 8'h01);
    wait_clk(3);
    chk("power", 8'h01, {7'h00, power_switch_out});
    // supply fault while the switch drives
    fault_cmd <= 1'b1;
    wait_clk(4);
    rd(`UPCD_A_HOST_STAT, 8'h01);
    rd(`UPCD_A_STATUS, 8'h01);
    rd(`UPCD_A_TOP_SUM, 8'h00);
    wr(`UPCD_A_HOST_EN, 8'h01);
    rd(`UPCD_A_TOP_SUM, 8'h02);
    wr(`UPCD_A_HOST_CTRL, 8'h00);
    fault_cmd <= 1'b0;
    wait_clk(4);
    wr(`UPCD_A_HOST_STAT, 8'h01);
    rd(`UPCD_A_HOST_STAT, 8'h00);
    // attach leaves se0 and moves the lines
    wr(`UPCD_A_HOST_EN, 8'h02);
    attach <= 1'b1;
    wait_clk(4);
    rd(`UPCD_A_HOST_STAT, 8'h02);
    rd(`UPCD_A_TOP_SUM, 8'h02);
    rd(`UPCD_A_STATUS, 8'h07);
    wr(`UPCD_A_HOST_STAT, 8'h02);
    wr(`UPCD_A_HOST_EN, 8'h00);
    rd(`UPCD_A_HOST_STAT, 8'h00);
    // supply moves are ignored in host role
    supply_on <= 1'b0;
    wait_clk(4);
    rd(`UPCD_A_DEV_STAT, 8'h00);
    rd(`UPCD_A_STATUS, 8'h06);
    wrap_up();
  end
endmodule

/* File: verification/upcd_peer_model.sv */
// cable peer and external power switch seen from the port
`timescale 1ns/1ps
module upcd_peer_model (
  // clock
  input wire logic clk,
  // scenario commands from the bench
  input wire logic supply_on,
  input wire logic fault_cmd,
  input wire logic attach,
  // pins of the block
  input wire logic power_switch_out,
  output logic vbus_in,
  output logic supply_fault_in,
  output logic [1:0] cable_line_level
);
  // a switch reports a fault only while it is driving, active low
  // lines sit at se0 through the host pull-downs while detached
  always @(posedge clk) begin
    vbus_in <= supply_on;
    supply_fault_in <= ~(fault_cmd & power_switch_out);
    cable_line_level <= attach ? 2'h1 : 2'h0;
  end
  initial begin
    vbus_in = 1'b0;
    supply_fault_in = 1'b1;
    cable_line_level = 2'h0;
  end
endmodule
